// file: hw/qcr_regs.sv
// Notes on behaviour
// - Auto-enqueue queues every prepared transmit frame
// - Space monitor raises status bit 6
// - Monitor and manual bits self-clear after transmit
// - Manual enqueue queues exactly one frame
// - Bit 12 flags duration threshold cause
// - Bit 11 flags byte-count threshold cause
// - Bit 10 flags frame-count threshold cause
// - Cause flags refresh on status bit 13 acknowledge
// - Receive interrupt needs matching enable bit
`default_nettype none
module qcr_regs
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  output logic             IRQ,
  input  wire logic        TX_FRAME_READY,
  input  wire logic        TX_DONE,
  input  wire logic [15:0] TX_FREE,
  output logic             TX_ENQUEUE,
  input  wire logic [15:0] RX_AGE,
  input  wire logic [15:0] RX_BYTES,
  input  wire logic [15:0] RX_FRAMES
);

  qcr_pkg::qcr_state_s    st_reg;
  qcr_pkg::qcr_state_s    st_next;
  qcr_pkg::qcr_rx_level_s rx_lvl;
  logic                   wr_txq;
  logic                   wr_rxq;
  logic                   wr_stat;
  logic [2:0]             rx_cond;
  logic                   space_hit;

  assign rx_lvl.age    = RX_AGE;
  assign rx_lvl.bytes  = RX_BYTES;
  assign rx_lvl.frames = RX_FRAMES;

  assign wr_txq  = WR && (ADDR == qcr_pkg::QCR_TXQ_CMD_OFS);
  assign wr_rxq  = WR && (ADDR == qcr_pkg::QCR_RXQ_CMD_OFS);
  assign wr_stat = WR && (ADDR == qcr_pkg::QCR_IRQ_STAT_OFS);

  // Order matches flag bits 12..10; strict "exceeds" compare
  assign rx_cond[2] = st_reg.rxq_cmd[qcr_pkg::QCR_RXQ_DUR_EN_BIT]
                      && (rx_lvl.age > st_reg.dur_thr);
  assign rx_cond[1] = st_reg.rxq_cmd[qcr_pkg::QCR_RXQ_BYTE_EN_BIT]
                      && (rx_lvl.bytes > st_reg.byte_thr);
  assign rx_cond[0] = st_reg.rxq_cmd[qcr_pkg::QCR_RXQ_FRAME_EN_BIT]
                      && (rx_lvl.frames > st_reg.frame_thr);

  assign space_hit = st_reg.txq_cmd[qcr_pkg::QCR_TXQ_MON_BIT]
                     && !st_reg.mon_fired
                     && (TX_FREE >= st_reg.space_req);

  always_comb
  begin
    st_next         = st_reg;
    st_next.enqueue = 1'b0;
    st_next.rdata   = 16'h0000;

    if (WR)
    begin
      case (ADDR)
        qcr_pkg::QCR_TXQ_CMD_OFS:   st_next.txq_cmd   = WDATA;
        qcr_pkg::QCR_DUR_THR_OFS:   st_next.dur_thr   = WDATA;
        qcr_pkg::QCR_BYTE_THR_OFS:  st_next.byte_thr  = WDATA;
        qcr_pkg::QCR_FRAME_THR_OFS: st_next.frame_thr = WDATA;
        qcr_pkg::QCR_SPACE_REQ_OFS: st_next.space_req = WDATA;
        qcr_pkg::QCR_IRQ_MASK_OFS:
          st_next.mask = WDATA & qcr_pkg::QCR_IRQ_USED_MASK;
        default: ;
      endcase
    end

    // Cause flag positions keep their value across host writes
    if (wr_rxq)
    begin
      st_next.rxq_cmd = (WDATA & ~qcr_pkg::QCR_RXQ_RO_MASK)
                        | (st_reg.rxq_cmd & qcr_pkg::QCR_RXQ_RO_MASK);
    end

    // Acknowledging the receive interrupt samples the live causes
    if (wr_stat && WDATA[qcr_pkg::QCR_IRQ_RX_BIT])
    begin
      st_next.rxq_cmd[qcr_pkg::QCR_RXQ_FLAG_MSB:qcr_pkg::QCR_RXQ_FLAG_LSB]
        = rx_cond;
    end

    // Re-arming the monitor allows one more space event
    if (wr_txq && WDATA[qcr_pkg::QCR_TXQ_MON_BIT])
    begin
      st_next.mon_fired = 1'b0;
    end
    else if (space_hit)
    begin
      st_next.mon_fired = 1'b1;
    end

    // Monitor bit drops once a frame completes, unless rearmed now
    if (TX_DONE && !(wr_txq && WDATA[qcr_pkg::QCR_TXQ_MON_BIT]))
    begin
      st_next.txq_cmd[qcr_pkg::QCR_TXQ_MON_BIT] = 1'b0;
    end

    case (st_reg.tx_state)
      qcr_pkg::QCR_ST_IDLE:
      begin
        // Manual wins if software breaks the exclusivity
        if (st_next.txq_cmd[qcr_pkg::QCR_TXQ_MAN_BIT])
        begin
          st_next.enqueue  = 1'b1;
          st_next.tx_state = qcr_pkg::QCR_ST_MANUAL;
        end
        else if (st_next.txq_cmd[qcr_pkg::QCR_TXQ_AUTO_BIT]
                 && TX_FRAME_READY)
        begin
          st_next.enqueue  = 1'b1;
          st_next.tx_state = qcr_pkg::QCR_ST_AUTO_GAP;
        end
      end
      qcr_pkg::QCR_ST_MANUAL:
      begin
        // One frame per command: no further enqueue until done
        if (TX_DONE)
        begin
          st_next.txq_cmd[qcr_pkg::QCR_TXQ_MAN_BIT] = 1'b0;
          st_next.tx_state = qcr_pkg::QCR_ST_IDLE;
        end
      end
      qcr_pkg::QCR_ST_AUTO_GAP:
      begin
        // Gap lets the ready level fall after the last frame is taken
        st_next.tx_state = qcr_pkg::QCR_ST_IDLE;
      end
      default:
      begin
        st_next.tx_state = qcr_pkg::QCR_ST_IDLE;
      end
    endcase

    // Sticky status: set wins over a same-cycle write-one clear
    if (wr_stat)
    begin
      st_next.status = st_reg.status & ~WDATA;
    end
    if (space_hit)
    begin
      st_next.status[qcr_pkg::QCR_IRQ_TX_SPACE_BIT] = 1'b1;
    end
    if (|rx_cond)
    begin
      st_next.status[qcr_pkg::QCR_IRQ_RX_BIT] = 1'b1;
    end
    st_next.status = st_next.status & qcr_pkg::QCR_IRQ_USED_MASK;

    st_next.irq = |(st_next.status & st_next.mask);

    if (RD)
    begin
      case (ADDR)
        qcr_pkg::QCR_TXQ_CMD_OFS:   st_next.rdata = st_reg.txq_cmd;
        qcr_pkg::QCR_RXQ_CMD_OFS:   st_next.rdata = st_reg.rxq_cmd;
        qcr_pkg::QCR_DUR_THR_OFS:   st_next.rdata = st_reg.dur_thr;
        qcr_pkg::QCR_BYTE_THR_OFS:  st_next.rdata = st_reg.byte_thr;
        qcr_pkg::QCR_FRAME_THR_OFS: st_next.rdata = st_reg.frame_thr;
        qcr_pkg::QCR_SPACE_REQ_OFS: st_next.rdata = st_reg.space_req;
        qcr_pkg::QCR_IRQ_STAT_OFS:  st_next.rdata = st_reg.status;
        qcr_pkg::QCR_IRQ_MASK_OFS:  st_next.rdata = st_reg.mask;
        default:                    st_next.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      st_reg           <= '0;
      st_reg.tx_state  <= qcr_pkg::QCR_ST_IDLE;
      st_reg.txq_cmd   <= qcr_pkg::QCR_REG_RESET;
      st_reg.rxq_cmd   <= qcr_pkg::QCR_REG_RESET;
      st_reg.status    <= qcr_pkg::QCR_REG_RESET;
      st_reg.mask      <= qcr_pkg::QCR_REG_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign RDATA      = st_reg.rdata;
  assign IRQ        = st_reg.irq;
  assign TX_ENQUEUE = st_reg.enqueue;

  default clocking qcr_cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  auto_enqueue_a: assert property (
    (st_reg.tx_state == qcr_pkg::QCR_ST_IDLE) && !WR
    && st_reg.txq_cmd[qcr_pkg::QCR_TXQ_AUTO_BIT]
    && !st_reg.txq_cmd[qcr_pkg::QCR_TXQ_MAN_BIT] && TX_FRAME_READY
    |=> TX_ENQUEUE ##1 !TX_ENQUEUE)
    else $error("auto enqueue did not issue one pulse");

  manual_single_a: assert property (
    (st_reg.tx_state == qcr_pkg::QCR_ST_MANUAL) |=> !TX_ENQUEUE)
    else $error("second enqueue during manual frame");

  manual_start_a: assert property (
    (st_reg.tx_state == qcr_pkg::QCR_ST_IDLE) && wr_txq
    && WDATA[qcr_pkg::QCR_TXQ_MAN_BIT]
    |=> TX_ENQUEUE && (st_reg.tx_state == qcr_pkg::QCR_ST_MANUAL))
    else $error("manual enqueue not issued");

  manual_clear_a: assert property (
    (st_reg.tx_state == qcr_pkg::QCR_ST_MANUAL) && TX_DONE && !wr_txq
    |=> !st_reg.txq_cmd[qcr_pkg::QCR_TXQ_MAN_BIT])
    else $error("manual bit not self-cleared");

  monitor_clear_a: assert property (
    TX_DONE && !wr_txq
    |=> !st_reg.txq_cmd[qcr_pkg::QCR_TXQ_MON_BIT])
    else $error("monitor bit not self-cleared");

  space_irq_a: assert property (
    st_reg.txq_cmd[qcr_pkg::QCR_TXQ_MON_BIT] && !st_reg.mon_fired
    && (TX_FREE >= st_reg.space_req)
    |=> st_reg.status[qcr_pkg::QCR_IRQ_TX_SPACE_BIT]
        && st_reg.mon_fired)
    else $error("space event not raised");

  dur_flag_a: assert property (
    wr_stat && WDATA[qcr_pkg::QCR_IRQ_RX_BIT]
    && st_reg.rxq_cmd[qcr_pkg::QCR_RXQ_DUR_EN_BIT]
    && (RX_AGE > st_reg.dur_thr)
    |=> st_reg.rxq_cmd[12])
    else $error("duration cause flag not set");

  byte_flag_a: assert property (
    wr_stat && WDATA[qcr_pkg::QCR_IRQ_RX_BIT]
    && (st_reg.rxq_cmd[qcr_pkg::QCR_RXQ_BYTE_EN_BIT]
        == (RX_BYTES > st_reg.byte_thr))
    |=> st_reg.rxq_cmd[11] == $past(st_reg.rxq_cmd[6]))
    else $error("byte cause flag wrong");

  frame_flag_a: assert property (
    wr_stat && WDATA[qcr_pkg::QCR_IRQ_RX_BIT]
    && st_reg.rxq_cmd[qcr_pkg::QCR_RXQ_FRAME_EN_BIT]
    && (RX_FRAMES > st_reg.frame_thr)
    |=> st_reg.rxq_cmd[10])
    else $error("frame cause flag not set");

  flags_hold_a: assert property (
    !(wr_stat && WDATA[qcr_pkg::QCR_IRQ_RX_BIT])
    |=> $stable(st_reg.rxq_cmd[12:10]))
    else $error("cause flags changed without acknowledge");

  flags_ro_a: assert property (
    wr_rxq && !wr_stat
    |=> st_reg.rxq_cmd[12:10] == $past(st_reg.rxq_cmd[12:10]))
    else $error("host write altered cause flags");

  rx_irq_a: assert property (
    $rose(st_reg.status[qcr_pkg::QCR_IRQ_RX_BIT])
    |-> ($past(rx_cond) != 3'h0))
    else $error("receive interrupt without enabled cause");

  enqueue_busy_a: assert property (
    TX_ENQUEUE |-> (st_reg.tx_state != qcr_pkg::QCR_ST_IDLE))
    else $error("enqueue pulse outside a transmit state");

  auto_gap_a: assert property (
    (st_reg.tx_state == qcr_pkg::QCR_ST_AUTO_GAP)
    |=> (st_reg.tx_state == qcr_pkg::QCR_ST_IDLE) && !TX_ENQUEUE)
    else $error("auto gap cycle not taken");

  tx_state_a: assert property (
    $onehot(st_reg.tx_state))
    else $error("transmit state not one-hot");

  manual_hold_a: assert property (
    (st_reg.tx_state == qcr_pkg::QCR_ST_MANUAL) && !TX_DONE
    |=> (st_reg.tx_state == qcr_pkg::QCR_ST_MANUAL))
    else $error("manual frame left before done");

  txq_store_a: assert property (
    wr_txq && !TX_DONE
    |=> (st_reg.txq_cmd == $past(WDATA)))
    else $error("transmit command write lost");

  monitor_once_a: assert property (
    st_reg.mon_fired && !(wr_txq && WDATA[qcr_pkg::QCR_TXQ_MON_BIT])
    |=> st_reg.mon_fired)
    else $error("space event rearmed without a write");

  space_quiet_a: assert property (
    !st_reg.txq_cmd[qcr_pkg::QCR_TXQ_MON_BIT]
    && !st_reg.status[qcr_pkg::QCR_IRQ_TX_SPACE_BIT]
    |=> !st_reg.status[qcr_pkg::QCR_IRQ_TX_SPACE_BIT])
    else $error("space event without monitor");

  space_sticky_a: assert property (
    st_reg.status[qcr_pkg::QCR_IRQ_TX_SPACE_BIT]
    && !(wr_stat && WDATA[qcr_pkg::QCR_IRQ_TX_SPACE_BIT])
    |=> st_reg.status[qcr_pkg::QCR_IRQ_TX_SPACE_BIT])
    else $error("space status lost without clear");

  rx_set_a: assert property (
    (rx_cond != 3'h0) |=> st_reg.status[qcr_pkg::QCR_IRQ_RX_BIT])
    else $error("enabled receive cause did not interrupt");

  rx_disabled_a: assert property (
    (st_reg.rxq_cmd[7:5] == 3'h0)
    && !st_reg.status[qcr_pkg::QCR_IRQ_RX_BIT]
    |=> !st_reg.status[qcr_pkg::QCR_IRQ_RX_BIT])
    else $error("receive interrupt with no enable");

  flag_read_a: assert property (
    RD && (ADDR == qcr_pkg::QCR_RXQ_CMD_OFS)
    |=> (RDATA == $past(st_reg.rxq_cmd)))
    else $error("command read data wrong");

  irq_level_a: assert property (
    IRQ == |(st_reg.status & st_reg.mask))
    else $error("interrupt output disagrees with status");

  rdata_idle_a: assert property (
    !RD |=> (RDATA == 16'h0000))
    else $error("read data stood without a read");

  status_used_a: assert property (
    (st_reg.status & ~qcr_pkg::QCR_IRQ_USED_MASK) == 16'h0000)
    else $error("unused status bit set");

  mask_used_a: assert property (
    (st_reg.mask & ~qcr_pkg::QCR_IRQ_USED_MASK) == 16'h0000)
    else $error("unused mask bit stored");

endmodule
`default_nettype wire

// file: hw/qcr_pkg.sv
`default_nettype none
package qcr_pkg;

  // Byte addresses on the 8-bit register address port
  localparam logic [7:0] QCR_TXQ_CMD_OFS   = 8'h80;
  localparam logic [7:0] QCR_RXQ_CMD_OFS   = 8'h82;
  localparam logic [7:0] QCR_DUR_THR_OFS   = 8'h8c;
  localparam logic [7:0] QCR_BYTE_THR_OFS  = 8'h8e;
  localparam logic [7:0] QCR_FRAME_THR_OFS = 8'h9c;
  localparam logic [7:0] QCR_SPACE_REQ_OFS = 8'h9e;
  localparam logic [7:0] QCR_IRQ_STAT_OFS  = 8'ha0;
  localparam logic [7:0] QCR_IRQ_MASK_OFS  = 8'ha2;

  // tx_queue_command fields
  localparam int QCR_TXQ_MAN_BIT  = 0;
  localparam int QCR_TXQ_MON_BIT  = 1;
  localparam int QCR_TXQ_AUTO_BIT = 2;

  // rx_queue_command fields
  localparam int QCR_RXQ_FRAME_EN_BIT   = 5;
  localparam int QCR_RXQ_BYTE_EN_BIT    = 6;
  localparam int QCR_RXQ_DUR_EN_BIT     = 7;
  localparam int QCR_RXQ_FLAG_LSB       = 10;
  localparam int QCR_RXQ_FLAG_MSB       = 12;
  localparam logic [15:0] QCR_RXQ_RO_MASK = 16'h1c00;

  // interrupt_status / mask fields
  localparam int QCR_IRQ_TX_SPACE_BIT = 6;
  localparam int QCR_IRQ_RX_BIT       = 13;
  localparam logic [15:0] QCR_IRQ_USED_MASK = 16'h2040;

  localparam logic [15:0] QCR_REG_RESET = 16'h0000;

  typedef enum logic [2:0]
  {
    QCR_ST_IDLE     = 3'b001,
    QCR_ST_MANUAL   = 3'b010,
    QCR_ST_AUTO_GAP = 3'b100
  } qcr_tx_state_e;

  // Receive-queue levels seen by the threshold comparators
  typedef struct packed {
    logic [15:0] age;
    logic [15:0] bytes;
    logic [15:0] frames;
  } qcr_rx_level_s;

  typedef struct packed {
    qcr_tx_state_e tx_state;
    logic [15:0]   txq_cmd;
    logic [15:0]   rxq_cmd;
    logic [15:0]   dur_thr;
    logic [15:0]   byte_thr;
    logic [15:0]   frame_thr;
    logic [15:0]   space_req;
    logic [15:0]   status;
    logic [15:0]   mask;
    logic          mon_fired;
    logic [15:0]   rdata;
    logic          irq;
    logic          enqueue;
  } qcr_state_s;

endpackage
`default_nettype wire

// file: verif/qcr_host.sv
`default_nettype none
module qcr_host
(
  input  wire logic        CLK,
  input  wire logic [15:0] RDATA,
  output var  logic [7:0]  ADDR,
  output var  logic [15:0] WDATA,
  output var  logic        WR,
  output var  logic        RD
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    ADDR = 8'h00;
    WDATA = 16'h0000;
    WR = 1'b0;
    RD = 1'b0;
  end
  // Strobes never overlap; each task owns the bus for whole cycles
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
endmodule
`default_nettype wire

// file: verif/qcr_regs_tb_top.sv
`default_nettype none
module qcr_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic [7:0]  ADDR;
  logic [15:0] WDATA, RDATA, TX_FREE, RX_AGE, RX_BYTES, RX_FRAMES, d;
  logic        WR, RD, IRQ, TX_FRAME_READY, TX_DONE, TX_ENQUEUE;
  int          num_errors = 0;
  int          tests_run = 0;
  int          enq_cnt = 0;
  initial
  begin
    TX_FRAME_READY = 1'b0;
    TX_DONE = 1'b0;
    TX_FREE = 16'h0008;
    {RX_AGE, RX_BYTES, RX_FRAMES} = 48'h0;
  end
  initial
  begin
    forever #12.5 CLK = ~CLK;
  end
  qcr_host host (.CLK(CLK), .RDATA(RDATA), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD));
  qcr_regs DUT (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .TX_FRAME_READY(TX_FRAME_READY),
    .TX_DONE(TX_DONE), .TX_FREE(TX_FREE), .TX_ENQUEUE(TX_ENQUEUE),
    .RX_AGE(RX_AGE), .RX_BYTES(RX_BYTES), .RX_FRAMES(RX_FRAMES));
  always @(posedge CLK)
  begin
    if (TX_ENQUEUE === 1'b1) enq_cnt++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic done_pulse();
    @(posedge CLK) TX_DONE <= 1'b1;
    @(posedge CLK) TX_DONE <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask
  task automatic t_reset();
    rdchk(qcr_pkg::QCR_TXQ_CMD_OFS, 16'h0000);
    rdchk(qcr_pkg::QCR_RXQ_CMD_OFS, 16'h0000);
    rdchk(qcr_pkg::QCR_IRQ_STAT_OFS, 16'h0000);
    rdchk(qcr_pkg::QCR_IRQ_MASK_OFS, 16'h0000);
    rdchk(8'h40, 16'h0000);
    chk({15'h0, IRQ}, 16'h0000);
  endtask
  task automatic t_manual();
    int base;
    base = enq_cnt;
    host.wr(qcr_pkg::QCR_TXQ_CMD_OFS, 16'h0001);
    repeat (5) @(posedge CLK);
    chk(16'(enq_cnt - base), 16'h0001);
    rdchk(qcr_pkg::QCR_TXQ_CMD_OFS, 16'h0001);
    done_pulse();
    rdchk(qcr_pkg::QCR_TXQ_CMD_OFS, 16'h0000);
    chk(16'(enq_cnt - base), 16'h0001);
  endtask
  task automatic t_auto();
    int base;
    host.wr(qcr_pkg::QCR_TXQ_CMD_OFS, 16'h0004);
    base = enq_cnt;
    @(posedge CLK) TX_FRAME_READY <= 1'b1;
    repeat (4) @(posedge CLK);
    TX_FRAME_READY <= 1'b0;
    repeat (3) @(posedge CLK);
    chk(16'(enq_cnt - base), 16'h0002);
    host.wr(qcr_pkg::QCR_TXQ_CMD_OFS, 16'h0000);
  endtask
  task automatic t_monitor();
    host.wr(qcr_pkg::QCR_SPACE_REQ_OFS, 16'h0010);
    rdchk(qcr_pkg::QCR_SPACE_REQ_OFS, 16'h0010);
    host.wr(qcr_pkg::QCR_IRQ_MASK_OFS, 16'hffff);
    rdchk(qcr_pkg::QCR_IRQ_MASK_OFS, 16'h2040);
    host.wr(qcr_pkg::QCR_TXQ_CMD_OFS, 16'h0002);
    rdchk(qcr_pkg::QCR_IRQ_STAT_OFS, 16'h0000);
    @(posedge CLK) TX_FREE <= 16'h0010;
    repeat (3) @(posedge CLK);
    rdchk(qcr_pkg::QCR_IRQ_STAT_OFS, 16'h0040);
    chk({15'h0, IRQ}, 16'h0001);
    host.wr(qcr_pkg::QCR_IRQ_MASK_OFS, 16'h0000);
    @(posedge CLK);
    chk({15'h0, IRQ}, 16'h0000);
    host.wr(qcr_pkg::QCR_IRQ_STAT_OFS, 16'h0040);
    rdchk(qcr_pkg::QCR_IRQ_STAT_OFS, 16'h0000);
    done_pulse();
    rdchk(qcr_pkg::QCR_TXQ_CMD_OFS, 16'h0000);
  endtask
  // Index 0 frame count, 1 byte count, 2 duration
  task automatic t_rx(input int i);
    logic [15:0] en;
    logic [7:0]  thr;
    en = 16'h0001 << (5 + i);
    thr = (i == 0) ? qcr_pkg::QCR_FRAME_THR_OFS
        : (i == 1) ? qcr_pkg::QCR_BYTE_THR_OFS : qcr_pkg::QCR_DUR_THR_OFS;
    host.wr(thr, 16'h0006);
    rdchk(thr, 16'h0006);
    // Level equal to threshold does not exceed it
    @(posedge CLK) {RX_AGE, RX_BYTES, RX_FRAMES} <= 48'h6 << (16 * i);
    host.wr(qcr_pkg::QCR_RXQ_CMD_OFS, en);
    host.wr(qcr_pkg::QCR_IRQ_STAT_OFS, 16'h2000);
    rdchk(qcr_pkg::QCR_IRQ_STAT_OFS, 16'h0000);
    host.wr(qcr_pkg::QCR_RXQ_CMD_OFS, 16'h0000);
    @(posedge CLK) {RX_AGE, RX_BYTES, RX_FRAMES} <= 48'h7 << (16 * i);
    host.wr(qcr_pkg::QCR_IRQ_STAT_OFS, 16'h2000);
    rdchk(qcr_pkg::QCR_IRQ_STAT_OFS, 16'h0000);
    host.wr(qcr_pkg::QCR_RXQ_CMD_OFS, en);
    host.wr(qcr_pkg::QCR_IRQ_MASK_OFS, 16'h2000);
    rdchk(qcr_pkg::QCR_IRQ_STAT_OFS, 16'h2000);
    chk({15'h0, IRQ}, 16'h0001);
    host.wr(qcr_pkg::QCR_IRQ_STAT_OFS, 16'h2000);
    rdchk(qcr_pkg::QCR_IRQ_STAT_OFS, 16'h2000);
    rdchk(qcr_pkg::QCR_RXQ_CMD_OFS, en | (16'h0400 << i));
    @(posedge CLK) {RX_AGE, RX_BYTES, RX_FRAMES} <= 48'h0;
    host.wr(qcr_pkg::QCR_RXQ_CMD_OFS, en | 16'h1c00);
    rdchk(qcr_pkg::QCR_RXQ_CMD_OFS, en | (16'h0400 << i));
    host.wr(qcr_pkg::QCR_IRQ_STAT_OFS, 16'h2000);
    rdchk(qcr_pkg::QCR_RXQ_CMD_OFS, en);
    rdchk(qcr_pkg::QCR_IRQ_STAT_OFS, 16'h0000);
    host.wr(qcr_pkg::QCR_IRQ_MASK_OFS, 16'h0000);
  endtask
  task automatic print_verdict();
    $display("errors=%0d comparisons=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    t_reset();
    t_manual();
    t_auto();
    t_monitor();
    for (int i = 0; i < 3; i++) t_rx(i);
    print_verdict();
  end
  // Whole run is a few hundred cycles
  initial
  begin
    #100000;
    num_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
